// *** core/pmt_pkg.sv ***
// Package with register map, field layout and reset values of the period timer
//
// Notes on behaviour
// - Counter and period register are 8 bits.
// - Input clock is core clock divided by four.
// - Counter counts up from zero by one.
// - Prescaler divides input by 1, 4 or 16.
// - Prescale ratio 1:64 is also selectable.
// - Compare counter with period each cycle; flag equality.
// - After a match the counter reloads zero, postscaler advances.
// - Match pulse lasts one prescaled input period.
// - Software reads and writes counter and period anytime.
// - Reset clears counter, sets period to all ones.
// - Counter or control writes and resets clear scalers.
// - Postscaler offers ratios 1:1 through 1:16.
// - Postscaler completion sets sticky flag until cleared.
// - Interrupt reaches processor only while enabled.
// - Match output is synchronous to the system clock.
// - No counting while the processor sleeps.
// - Counter and period kept unchanged during sleep.
package pmt_pkg;
    // Register word offsets (byte addresses)
    localparam logic [3:0] ADDR_COUNTER = 4'h0;
    localparam logic [3:0] ADDR_LIMIT = 4'h4;
    localparam logic [3:0] ADDR_CONTROL = 4'h8;
    localparam logic [3:0] ADDR_IRQ_ENABLE = 4'hc;
    localparam logic [3:0] ADDR_IRQ_FLAGS = 4'h0;
    // Flags register sits at a separate word; upper nibble selects it
    localparam logic [4:0] WORD_COUNTER = 5'h00;
    localparam logic [4:0] WORD_LIMIT = 5'h01;
    localparam logic [4:0] WORD_CONTROL = 5'h02;
    localparam logic [4:0] WORD_IRQ_ENABLE = 5'h03;
    localparam logic [4:0] WORD_IRQ_FLAGS = 5'h04;
    // Field positions
    localparam int CTRL_PRESCALE_LSB = 0;
    localparam int CTRL_ON_BIT = 2;
    localparam int CTRL_POSTSCALE_LSB = 3;
    localparam int IRQ_MATCH_BIT = 1;
    // Values after reset
    localparam logic [7:0] COUNTER_RESET = 8'h00;
    localparam logic [7:0] LIMIT_RESET = 8'hff;
    localparam logic [6:0] CONTROL_RESET = 7'h00;
    // Instruction clock is the core clock divided by four
    localparam int INSTR_CLOCK_DIV = 4;
    localparam logic [1:0] INSTR_DIV_LAST = 2'(INSTR_CLOCK_DIV - 1);
    // Prescale codes
    typedef enum logic [1:0] {
        PRE_DIV1 = 2'h0,
        PRE_DIV4 = 2'h1,
        PRE_DIV16 = 2'h2,
        PRE_DIV64 = 2'h3
    } pmt_prescale_type;
endpackage : pmt_pkg

// *** core/pmt_tick_if.sv ***
// Interface carrying tick and scaler control between timer modules
`timescale 1ns/1ps
interface pmt_tick_if;
    logic instrTick;
    logic scalerClear;
    logic [1:0] prescaleSelect;
    logic prescaleTick;
    modport source (output instrTick, output scalerClear, output prescaleSelect,
        input prescaleTick);
    modport scaler (input instrTick, input scalerClear, input prescaleSelect,
        output prescaleTick);
endinterface : pmt_tick_if

// *** core/pmt_prescaler.sv ***
// Prescaler producing one enable pulse per selected ratio of instruction ticks
`timescale 1ns/1ps
module pmt_prescaler #(
    parameter int WIDTH = 6
) (
    input wire logic core_clk,
    input wire logic resetn,
    pmt_tick_if.scaler tick
);
    logic [WIDTH-1:0] count_r;
    logic [WIDTH-1:0] count_nxt;
    logic [WIDTH-1:0] lastCount;

    // Terminal count per code: 0, 3, 15, 63
    assign lastCount = (tick.prescaleSelect == pmt_pkg::PRE_DIV1) ? WIDTH'(0) :
                       (tick.prescaleSelect == pmt_pkg::PRE_DIV4) ? WIDTH'(3) :
                       (tick.prescaleSelect == pmt_pkg::PRE_DIV16) ? WIDTH'(15) : WIDTH'(63);
    assign tick.prescaleTick = tick.instrTick && (count_r >= lastCount);
    assign count_nxt = tick.scalerClear ? '0 :
                       !tick.instrTick ? count_r :
                       tick.prescaleTick ? '0 : count_r + WIDTH'(1);

    // Cleared by counter or control writes and reset
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end
endmodule : pmt_prescaler

// *** core/period_match_timer.sv ***
// Top of the 8-bit period match timer with Avalon-MM register slave
`timescale 1ns/1ps
module period_match_timer #(
    parameter int WIDTH = 8
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [4:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWritedata,
    input wire logic [3:0] avsByteenable,
    output logic [31:0] avsReaddata,
    output logic avsWaitrequest,
    input wire logic sleepMode,
    output logic periodMatchPulse,
    output logic matchIrq
);
    pmt_tick_if tick ();

    logic [WIDTH-1:0] periodCounter_r;
    logic [WIDTH-1:0] periodCounter_nxt;
    logic [WIDTH-1:0] periodLimit_r;
    logic [WIDTH-1:0] periodLimit_nxt;
    logic [6:0] control_r;
    logic [6:0] control_nxt;
    logic matchIrqEnable_r;
    logic matchIrqFlag_r;
    logic matchIrqFlag_nxt;
    logic [1:0] instrDiv_r;
    logic [3:0] postCount_r;
    logic [3:0] postCount_nxt;
    logic matchPulse_r;
    logic [31:0] readData_r;
    logic readDone_r;

    // Decoded register bus access
    logic lane0;
    logic wrCounter;
    logic wrLimit;
    logic wrControl;
    logic wrEnable;
    logic wrFlags;
    logic timerOn;
    logic [1:0] prescaleSelect;
    logic [3:0] postscaleSelect;
    logic countStep;
    logic isMatch;
    logic postDone;
    logic [31:0] readMux;

    // Write strobe for one word; every operand is an argument so the
    // continuous assignments that call it re-evaluate on each of them
    function automatic logic writeHit(
        input logic wrReq,
        input logic laneOn,
        input logic [4:0] addr,
        input logic [4:0] word
    );
        return wrReq && laneOn && (addr == word);
    endfunction : writeHit

    assign lane0 = avsByteenable[0];
    assign wrCounter = writeHit(avsWrite, lane0, avsAddress, pmt_pkg::WORD_COUNTER);
    assign wrLimit = writeHit(avsWrite, lane0, avsAddress, pmt_pkg::WORD_LIMIT);
    assign wrControl = writeHit(avsWrite, lane0, avsAddress, pmt_pkg::WORD_CONTROL);
    assign wrEnable = writeHit(avsWrite, lane0, avsAddress, pmt_pkg::WORD_IRQ_ENABLE);
    assign wrFlags = writeHit(avsWrite, lane0, avsAddress, pmt_pkg::WORD_IRQ_FLAGS);

    // Control fields
    assign prescaleSelect = control_r[pmt_pkg::CTRL_PRESCALE_LSB +: 2];
    assign timerOn = control_r[pmt_pkg::CTRL_ON_BIT];
    assign postscaleSelect = control_r[pmt_pkg::CTRL_POSTSCALE_LSB +: 4];

    // Instruction clock enable: one pulse every four core cycles
    assign tick.instrTick = (instrDiv_r == pmt_pkg::INSTR_DIV_LAST) && timerOn && !sleepMode;
    assign tick.prescaleSelect = prescaleSelect;
    // Any counter or control write empties both scalers
    assign tick.scalerClear = wrCounter || wrControl;

    pmt_prescaler #(
        .WIDTH(6)
    ) u_prescaler (
        .core_clk(core_clk),
        .resetn(resetn),
        .tick(tick)
    );

    // Counting gated by on bit and sleep
    assign countStep = tick.prescaleTick;
    // Equality checked every cycle
    assign isMatch = (periodCounter_r == periodLimit_r);
    // Postscaler completes at N+1 matches
    assign postDone = countStep && isMatch && (postCount_r == postscaleSelect);

    // Counter: reload on prescaled tick after match, else increment
    assign periodCounter_nxt = wrCounter ? avsWritedata[WIDTH-1:0] :
                               !countStep ? periodCounter_r :
                               isMatch ? '0 : periodCounter_r + WIDTH'(1);
    assign periodLimit_nxt = wrLimit ? avsWritedata[WIDTH-1:0] : periodLimit_r;
    assign control_nxt = wrControl ? avsWritedata[6:0] : control_r;
    assign postCount_nxt = tick.scalerClear ? 4'h0 :
                           !(countStep && isMatch) ? postCount_r :
                           postDone ? 4'h0 : postCount_r + 4'h1;
    // Set wins over a software clear in the same cycle
    assign matchIrqFlag_nxt = postDone ? 1'b1 :
                              wrFlags ? avsWritedata[pmt_pkg::IRQ_MATCH_BIT] : matchIrqFlag_r;

    // Read data multiplexer, unmapped words read zero
    assign readMux = (avsAddress == pmt_pkg::WORD_COUNTER) ? 32'(periodCounter_r) :
                     (avsAddress == pmt_pkg::WORD_LIMIT) ? 32'(periodLimit_r) :
                     (avsAddress == pmt_pkg::WORD_CONTROL) ? 32'(control_r) :
                     (avsAddress == pmt_pkg::WORD_IRQ_ENABLE) ?
                         32'({matchIrqEnable_r, 1'b0}) :
                     (avsAddress == pmt_pkg::WORD_IRQ_FLAGS) ?
                         32'({matchIrqFlag_r, 1'b0}) : 32'h0000_0000;

    // Reads take one wait cycle; writes complete at once
    assign avsWaitrequest = avsRead && !readDone_r;
    assign avsReaddata = readData_r;

    // Match output held for one prescaled period, clocked by core clock
    assign periodMatchPulse = matchPulse_r;
    // Interrupt gated by enable
    assign matchIrq = matchIrqFlag_r && matchIrqEnable_r;

    // Instruction divider free-runs; it sets phase, not state
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            instrDiv_r <= 2'h0;
        end else begin
            instrDiv_r <= instrDiv_r + 2'h1;
        end
    end

    // Timer registers; sleep only stops ticks so contents stay
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            periodCounter_r <= pmt_pkg::COUNTER_RESET;
            periodLimit_r <= pmt_pkg::LIMIT_RESET;
            control_r <= pmt_pkg::CONTROL_RESET;
            postCount_r <= 4'h0;
        end else begin
            periodCounter_r <= periodCounter_nxt;
            periodLimit_r <= periodLimit_nxt;
            control_r <= control_nxt;
            postCount_r <= postCount_nxt;
        end
    end

    // Match pulse: raised at matching tick, dropped at the next tick
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            matchPulse_r <= 1'b0;
        end else if (countStep) begin
            matchPulse_r <= isMatch;
        end else if (!timerOn) begin
            matchPulse_r <= 1'b0;
        end
    end

    // Interrupt enable and flag registers
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            matchIrqEnable_r <= 1'b0;
            matchIrqFlag_r <= 1'b0;
        end else begin
            if (wrEnable) begin
                matchIrqEnable_r <= avsWritedata[pmt_pkg::IRQ_MATCH_BIT];
            end
            matchIrqFlag_r <= matchIrqFlag_nxt;
        end
    end

    // Read data captured in the wait cycle
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            readData_r <= 32'h0000_0000;
            readDone_r <= 1'b0;
        end else begin
            readDone_r <= avsRead && !readDone_r;
            if (avsRead && !readDone_r) begin
                readData_r <= readMux;
            end
        end
    end
endmodule : period_match_timer

// *** testbench/pmt_assertions.sv ***
// Port-level checks of the period timer
`timescale 1ns/1ps
module pmt_assertions #(
    parameter int WIDTH = 8
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [4:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWritedata,
    input wire logic [3:0] avsByteenable,
    input wire logic [31:0] avsReaddata,
    input wire logic avsWaitrequest,
    input wire logic sleepMode,
    input wire logic periodMatchPulse,
    input wire logic matchIrq
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    // Read data is only meaningful in the answering cycle
    wire logic rdDone = avsRead && !avsWaitrequest;
    property p_rd_wait; $rose(avsRead) |-> avsWaitrequest; endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read not held");
    property p_rd_ans; avsRead && avsWaitrequest |=> !avsWaitrequest; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read late");
    property p_wr_go; avsWrite |-> !avsWaitrequest; endproperty
    a_wr_go: assert property (p_wr_go) else $error("write stalled");
    property p_hi_zero; rdDone |-> avsReaddata[31:8] == 24'h0; endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("upper bits set");
    property p_unmap; rdDone && avsAddress > 5'h4 |-> avsReaddata == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_gate; rdDone && avsAddress == 5'h3 && !avsReaddata[1] |-> !matchIrq; endproperty
    a_gate: assert property (p_gate) else $error("irq while disabled");
    property p_sticky; $fell(matchIrq) |-> $past(avsWrite); endproperty
    a_sticky: assert property (p_sticky) else $error("flag lost");
    property p_sleep;
        sleepMode && $past(sleepMode) && $past(sleepMode, 2) |-> !$rose(periodMatchPulse);
    endproperty
    a_sleep: assert property (p_sleep) else $error("match in sleep");
    property p_width;
        $fell(periodMatchPulse) |-> $past(periodMatchPulse, 4) || $past(avsWrite)
            || $past(avsWrite, 2);
    endproperty
    a_width: assert property (p_width) else $error("pulse short");
endmodule : pmt_assertions
bind period_match_timer pmt_assertions #(.WIDTH(WIDTH)) chk_u (.core_clk, .resetn,
    .avsAddress, .avsRead, .avsWrite, .avsWritedata, .avsByteenable, .avsReaddata,
    .avsWaitrequest, .sleepMode, .periodMatchPulse, .matchIrq);

// *** testbench/period_match_timer_tb.sv ***
// Register-level bench of the period timer
`timescale 1ns/1ps
module period_match_timer_tb;
    logic core_clk, resetn, avsRead, avsWrite, sleepMode;
    logic [4:0] avsAddress;
    logic [31:0] avsWritedata, avsReaddata;
    logic [3:0] avsByteenable;
    logic avsWaitrequest, periodMatchPulse, matchIrq;
    int fails, cmp_count, cycles, w, l, cnt;
    int ps[3] = '{0, 2, 15};
    period_match_timer #(.WIDTH(8)) dut_u (.core_clk, .resetn, .avsAddress, .avsRead,
        .avsWrite, .avsWritedata, .avsByteenable, .avsReaddata, .avsWaitrequest,
        .sleepMode, .periodMatchPulse, .matchIrq);
    // 125 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task automatic stop_test();
        if (fails == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test
    // Hang guard, well above the few thousand cycles needed
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            fails++;
            stop_test();
        end
    end
    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : check
    // Request held until waitrequest is sampled low, then one idle edge
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        avsAddress <= a;
        avsWritedata <= {24'h0, d};
        avsWrite <= 1'b1;
        do @(posedge core_clk); while (avsWaitrequest !== 1'b0);
        avsWrite <= 1'b0;
        @(posedge core_clk);
    endtask : wr
    task automatic rdc(input logic [4:0] a, input logic [31:0] e);
        logic [31:0] v;
        avsAddress <= a;
        avsRead <= 1'b1;
        do @(posedge core_clk); while (avsWaitrequest !== 1'b0);
        v = avsReaddata;
        avsRead <= 1'b0;
        @(posedge core_clk);
        check($sformatf("reg %0d", a), e, v);
    endtask : rdc
    // High time, then low time up to the next rise
    task automatic shape(output int hi, output int lo);
        hi = 0;
        lo = 0;
        while (periodMatchPulse === 1'b1) begin
            @(posedge core_clk);
            hi++;
        end
        while (periodMatchPulse !== 1'b1) begin
            @(posedge core_clk);
            lo++;
        end
    endtask : shape
    initial begin
        {resetn, avsRead, avsWrite, sleepMode, avsAddress, avsWritedata} = '0;
        {fails, cmp_count, cycles} = '0;
        avsByteenable = 4'hf;
        repeat (12) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        rdc(5'h0, 32'h0);
        rdc(5'h1, 32'hff);
        rdc(5'h7, 32'h0);
        wr(5'h1, 8'h5a);
        rdc(5'h1, 32'h5a);
        wr(5'h0, 8'h2a);
        wr(5'h2, 8'h00);
        rdc(5'h0, 32'h2a);
        avsByteenable <= 4'h0;
        wr(5'h0, 8'h11);
        avsByteenable <= 4'hf;
        rdc(5'h0, 32'h2a);
        repeat (40) @(posedge core_clk);
        rdc(5'h0, 32'h2a);
        wr(5'h0, 8'h00);
        wr(5'h1, 8'h03);
        // Each prescale code: width one scaled period, match every four counts
        for (int c = 0; c < 4; c++) begin
            wr(5'h2, 8'(4 + c));
            shape(w, l);
            shape(w, l);
            check("width", 32'(4 << (2 * c)), 32'(w));
            check("period", 32'(16 << (2 * c)), 32'(w + l));
        end
        wr(5'h3, 8'h02);
        // Flag must appear on the (N+1)th match
        for (int i = 0; i < 3; i++) begin
            wr(5'h2, 8'h00);
            wr(5'h4, 8'h00);
            wr(5'h2, 8'(ps[i] * 8 + 4));
            cnt = 0;
            while (matchIrq !== 1'b1) begin
                shape(w, l);
                cnt++;
                @(posedge core_clk);
            end
            check("matches", 32'(ps[i] + 1), 32'(cnt));
        end
        wr(5'h3, 8'h00);
        check("masked irq", 32'h0, 32'(matchIrq));
        rdc(5'h4, 32'h2);
        wr(5'h3, 8'h02);
        check("irq", 32'h1, 32'(matchIrq));
        sleepMode <= 1'b1;
        wr(5'h0, 8'h01);
        repeat (200) @(posedge core_clk);
        rdc(5'h0, 32'h1);
        rdc(5'h1, 32'h3);
        // Mid-run reset while the timer runs with the interrupt pending
        sleepMode <= 1'b0;
        repeat (20) @(posedge core_clk);
        resetn <= 1'b0;
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        check("irq after reset", 32'h0, 32'(matchIrq));
        rdc(5'h0, 32'h0);
        rdc(5'h1, 32'hff);
        rdc(5'h2, 32'h0);
        rdc(5'h4, 32'h0);
        stop_test();
    end
endmodule : period_match_timer_tb
